// [hw/fbrc_burst_read.v]
// Burst read setup word and synchronous burst sequencer
`timescale 1ns/100ps
`include "fbrc_defines.vh"

module fbrc_burst_read (
  input wire REF_CLK,
  input wire NRST,
  input wire SETUP_WR,
  input wire [15:0] SETUP_DATA,
  input wire BURST_CLK,
  input wire ADDR_LATCH_N,
  input wire ADVANCE_N,
  input wire CHIP_EN_N,
  input wire WORD_X32,
  input wire [21:0] ADDR,
  output wire [15:0] SETUP_WORD,
  output reg SETUP_REJECT,
  output wire SYNC_READ,
  output wire LATCH_CTRL_READ,
  output reg [21:0] BURST_ADDR,
  output reg BEAT_STB,
  output wire BURST_BUSY,
  output wire READY_O,
  output wire READY_OE_N
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'h1; // No burst running
  localparam ST_LAT = 4'h2;  // Counting first latency
  localparam ST_WAIT = 4'h4; // Internal fetch, not-ready shown
  localparam ST_DATA = 4'h8; // Presenting data beats

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------

  // Latency code to cycles, zero for a reserved code
  function [4:0] lat_of;
    input [3:0] code;
    begin
      case (code) // R5
        `FBRC_XC7: lat_of = `FBRC_XV7;
        `FBRC_XC8: lat_of = `FBRC_XV8;
        `FBRC_XC9: lat_of = `FBRC_XV9;
        `FBRC_XC10: lat_of = `FBRC_XV10;
        `FBRC_XC11: lat_of = `FBRC_XV11;
        `FBRC_XC12: lat_of = `FBRC_XV12;
        `FBRC_XC13: lat_of = `FBRC_XV13;
        `FBRC_XC14: lat_of = `FBRC_XV14;
        `FBRC_XC16: lat_of = `FBRC_XV16;
        default: lat_of = `FBRC_XNONE;
      endcase
    end
  endfunction

  // Length code to block mask; also tells if the code is listed
  function [3:0] len_of;
    input [2:0] code;
    begin
      case (code) // R11
        `FBRC_LEN1: len_of = {1'b1, `FBRC_MASK1};
        `FBRC_LEN2: len_of = {1'b1, `FBRC_MASK2};
        `FBRC_LEN4: len_of = {1'b1, `FBRC_MASK4};
        `FBRC_LEN8: len_of = {1'b1, `FBRC_MASK8};
        `FBRC_LENC: len_of = {1'b1, `FBRC_MASK8};
        default: len_of = {1'b0, `FBRC_MASK1};
      endcase
    end
  endfunction

  // Whole-word check of a setup write
  function wr_ok;
    input [15:0] w;
    input x32;
    reg [4:0] x;
    reg [3:0] ln;
    reg cont;
    begin
      x = lat_of(w[`FBRC_LAT_HI:`FBRC_LAT_LO]);
      ln = len_of(w[`FBRC_LEN_HI:`FBRC_LEN_LO]);
      cont = (w[`FBRC_LEN_HI:`FBRC_LEN_LO] == `FBRC_LENC);
      // Asynchronous words leave the burst fields unused
      wr_ok = w[`FBRC_RSEL] |
        ((x != `FBRC_XNONE) && ln[3] && // R23
         !(x == `FBRC_XV7 && !cont) && // R2
         !(cont && !w[`FBRC_ORD]) && // R12
         !(x32 && w[`FBRC_LEN_HI:`FBRC_LEN_LO] == `FBRC_LEN8)); // R13
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // All pins come from the controller, outside our clock
  wire [26:0] pin_raw;
  wire [26:0] pin_s;
  wire [26:0] pin_rst = `FBRC_PIN_RST; // Idle level of each pin
  assign pin_raw = {ADDR, WORD_X32, CHIP_EN_N, ADVANCE_N, ADDR_LATCH_N, BURST_CLK};

  // Two flops per pin; the address rides with its strobe, so the
  // same delay keeps them aligned. Skew on a changing address is
  // the controller's to avoid by holding it around the strobe.
  genvar gi;
  generate
    for (gi = 0; gi < `FBRC_PIN_W; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      always @(posedge REF_CLK) begin
        if (!NRST) begin
          s1 <= pin_rst[gi];
          s2 <= pin_rst[gi];
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
        end
      end
      assign pin_s[gi] = s2;
    end
  endgenerate

  wire k = pin_s[`FBRC_P_K];       // Burst clock level
  wire l_n = pin_s[`FBRC_P_L];     // Address strobe, low active
  wire b_n = pin_s[`FBRC_P_B];     // Advance, low active
  wire e_n = pin_s[`FBRC_P_E];     // Chip enable, low active
  wire x32 = pin_s[`FBRC_P_W];     // Double-word organisation
  wire [21:0] a = pin_s[`FBRC_PIN_W-1:`FBRC_P_A]; // Address

  // ----------------------------------------------------------------
  // Setup word and its fields
  // ----------------------------------------------------------------
  reg [15:0] setup;  // Stored setup word
  reg k_prev;        // Burst clock one sample ago
  reg l_prev;        // Strobe one sample ago

  wire sync_on = ~setup[`FBRC_RSEL]; // R21
  wire async_latch = setup[`FBRC_ASYNC]; // Strobe-captured read
  wire [4:0] lat_x = lat_of(setup[`FBRC_LAT_HI:`FBRC_LAT_LO]);
  wire [1:0] y_lat = setup[`FBRC_NEXT] ? `FBRC_Y2 : `FBRC_Y1; // R4
  wire rdy_early = setup[`FBRC_RDY]; // Not-ready one cycle early
  wire seq = setup[`FBRC_ORD]; // R8
  wire edge_rise = setup[`FBRC_EDGE]; // Active burst clock edge
  wire [3:0] len_info = len_of(setup[`FBRC_LEN_HI:`FBRC_LEN_LO]);
  wire [2:0] mask = len_info[2:0]; // Block mask of the length
  wire cont = (setup[`FBRC_LEN_HI:`FBRC_LEN_LO] == `FBRC_LENC);
  wire [3:0] len_cnt = {1'b0, mask} + 4'h1; // Beats per wrapped burst

  // Overlap is only legal for blocks of four, or eight in x16
  wire pipe_ok = !cont && ((mask == `FBRC_MASK4) ||
    (mask == `FBRC_MASK8 && !x32)); // R20

  // Active edge of the burst clock, picked by the edge bit
  wire kedge = edge_rise ? (k & ~k_prev) : (~k & k_prev); // R9

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  reg [3:0] state;      // One-hot sequencer state
  reg [4:0] lat_cnt;    // Edges left to the first datum
  reg [4:0] fetch_cnt;  // Edges left in the fetch wait
  reg [1:0] y_cnt;      // Edges left to the next datum
  reg [3:0] beat;       // Index of the next beat to present
  reg [21:0] start;     // Captured start address
  reg [21:0] cur;       // Address presented last
  reg pend_v;           // Overlapped address waiting
  reg [21:0] pend_addr; // Overlapped start address
  reg [4:0] pend_cnt;   // Its latency, counting meanwhile
  reg r_low;            // Not-ready being driven

  wire unal = (start[`FBRC_ALIGN_HI:0] != 2'h0); // Off a four-word line
  wire done = (state == ST_DATA) && !cont && (beat == len_cnt);
  wire [21:0] wrap_addr; // Next address inside the block

  // Next address of a wrapped burst
  fbrc_order u_order (
    .start(start),
    .beat(beat[2:0]),
    .mask(mask),
    .seq(seq),
    .addr(wrap_addr)
  );

  // Continuous bursts run linearly and roll over at the top
  wire [21:0] next_addr = cont ? cur + 22'h000001 : wrap_addr;

  // ----------------------------------------------------------------
  // Not-ready indication
  // ----------------------------------------------------------------

  // Early timing raises it one edge sooner and drops it one sooner
  wire next_r_low = rdy_early ?
    ((state == ST_WAIT && fetch_cnt > `FBRC_LAST) ||
     (state == ST_LAT && lat_cnt == `FBRC_LAST && cont && unal)) :
    (state == ST_WAIT && !(kedge && fetch_cnt == `FBRC_LAST)); // R7

  // ----------------------------------------------------------------
  // Setup word write
  // ----------------------------------------------------------------

  // A rejected word leaves the old setting alone and flags it,
  // so the sequencer never runs on an undefined code
  always @(posedge REF_CLK) begin
    if (!NRST) begin
      setup <= `FBRC_SETUP_RST;
      SETUP_REJECT <= 1'b0;
    end else if (SETUP_WR) begin
      if (wr_ok(SETUP_DATA, x32)) begin
        setup <= SETUP_DATA;
        SETUP_REJECT <= 1'b0;
      end else begin
        SETUP_REJECT <= 1'b1; // R23
      end
    end
  end

  // ----------------------------------------------------------------
  // Edge history and not-ready register
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (!NRST) begin
      k_prev <= 1'b0;
      l_prev <= 1'b1;
      r_low <= 1'b0;
    end else begin
      k_prev <= k;
      l_prev <= l_n;
      r_low <= next_r_low; // R16
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------

  // Burst steps move only on the active burst clock edge; asynchronous reads and deselect act on any cycle
  always @(posedge REF_CLK) begin
    if (!NRST) begin
      state <= ST_IDLE;
      lat_cnt <= `FBRC_XNONE;
      fetch_cnt <= `FBRC_XNONE;
      y_cnt <= `FBRC_Y1;
      beat <= 4'h0;
      start <= 22'h000000;
      cur <= 22'h000000;
      pend_v <= 1'b0;
      pend_addr <= 22'h000000;
      pend_cnt <= `FBRC_XNONE;
      BURST_ADDR <= 22'h000000;
      BEAT_STB <= 1'b0;
    end else begin
      BEAT_STB <= 1'b0;
      if (!sync_on) begin
        // Asynchronous read: the sequencer sits idle
        state <= ST_IDLE;
        pend_v <= 1'b0;
        if (!async_latch || (l_n && !l_prev)) begin
          BURST_ADDR <= a; // R10
        end
      end else if (e_n) begin
        // Deselect aborts the burst and any queued address
        state <= ST_IDLE;
        pend_v <= 1'b0;
      end else if (kedge) begin
        // Queue a next address while a burst is still running, latency count included
        if (!l_n && state != ST_IDLE && pipe_ok && !pend_v && !done) begin
          pend_v <= 1'b1; // R18
          pend_addr <= a;
          pend_cnt <= lat_x;
        end else if (pend_v && pend_cnt > `FBRC_LAST) begin
          pend_cnt <= pend_cnt - `FBRC_LAST;
        end
        case (state)
          ST_IDLE: begin
            // Capture the start address on the active edge
            if (!l_n) begin
              start <= a;
              lat_cnt <= lat_x; // R1
              state <= ST_LAT;
            end
          end
          ST_LAT: begin
            if (lat_cnt == `FBRC_LAST) begin
              if (cont && unal) begin
                // Fetch the next four words before any data
                fetch_cnt <= `FBRC_FETCH; // R17
                state <= ST_WAIT;
              end else begin
                BURST_ADDR <= start; // R1
                cur <= start;
                BEAT_STB <= 1'b1;
                beat <= 4'h1;
                y_cnt <= y_lat;
                state <= ST_DATA;
              end
            end else begin
              lat_cnt <= lat_cnt - `FBRC_LAST;
            end
          end
          ST_WAIT: begin
            // Advance is ignored while not-ready is shown
            if (fetch_cnt == `FBRC_LAST) begin
              BURST_ADDR <= start;
              cur <= start;
              BEAT_STB <= 1'b1;
              beat <= 4'h1;
              y_cnt <= y_lat;
              state <= ST_DATA;
            end else begin
              fetch_cnt <= fetch_cnt - `FBRC_LAST; // R22
            end
          end
          ST_DATA: begin
            if (done) begin
              // Last beat shown: start the queued burst, if any
              if (pend_v && pend_cnt > `FBRC_LAST) begin
                start <= pend_addr;
                lat_cnt <= pend_cnt - `FBRC_LAST; // R18
                pend_v <= 1'b0;
                state <= ST_LAT;
              end else if (pend_v) begin
                // Its latency is used up: first datum on this very edge
                start <= pend_addr;
                BURST_ADDR <= pend_addr; // R1
                cur <= pend_addr;
                BEAT_STB <= 1'b1;
                beat <= 4'h1;
                y_cnt <= y_lat;
                pend_v <= 1'b0;
              end else if (!l_n) begin
                start <= a;
                lat_cnt <= lat_x;
                state <= ST_LAT;
              end else begin
                state <= ST_IDLE;
              end
            end else if (y_cnt != `FBRC_Y1) begin
              y_cnt <= y_cnt - `FBRC_Y1; // R3
            end else if (!b_n) begin
              // Advance held low: present the next datum
              BURST_ADDR <= next_addr; // R15
              cur <= next_addr;
              BEAT_STB <= 1'b1;
              beat <= beat + 4'h1;
              y_cnt <= y_lat; // R3
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Open drain: only ever pulls low, enable low while driving
  assign READY_O = 1'b0;
  assign READY_OE_N = ~r_low; // R7
  assign SETUP_WORD = setup;
  assign SYNC_READ = sync_on;
  assign LATCH_CTRL_READ = ~sync_on & async_latch;
  assign BURST_BUSY = ~state[0];

endmodule

// [hw/fbrc_defines.vh]
// Constants for the flash burst read setup word and burst sequencer
// How it works
// R1 - First datum X cycles after address capture
// R2 - X latency 7..16, 7 continuous only
// R3 - Later data every Y cycles, Y one/two
// R4 - Next latency bit: 0 one, 1 two cycles
// R5 - Latency codes decode to 7..16, 0001 reserved
// R6 - Controller picks latency fitting its clock rate
// R7 - Ready timing: at edge or one before
// R8 - Ordering bit: 0 interleaved, 1 sequential
// R9 - Clock edge bit: 0 falling, 1 rising
// R10 - Async mode: random or strobe captured address
// R11 - Length codes: 1, 2, 4, 8, continuous
// R12 - Continuous length only with sequential ordering
// R13 - Controller never sets length eight in x32
// R14 - Burst wraps inside its aligned length block
// R15 - Sequential adds beat, interleaved XORs beat
// R16 - Aligned continuous burst never shows not-ready
// R17 - Unaligned continuous burst starts with not-ready fetch
// R18 - Next address may overlap current data phase
// R19 - Controller captures next address six edges early
// R20 - Overlap only lengths four/eight x16, four x32
// R21 - Read select: synchronous burst or asynchronous
// R22 - No advance while not-ready is shown
// R23 - Reserved codes rejected, previous setting kept
`ifndef FBRC_DEFINES_VH
`define FBRC_DEFINES_VH

// ----------------------------------------------------------------
// Setup word field positions
// ----------------------------------------------------------------
`define FBRC_RSEL 15
`define FBRC_LAT_HI 14
`define FBRC_LAT_LO 11
`define FBRC_NEXT 9
`define FBRC_RDY 8
`define FBRC_ORD 7
`define FBRC_EDGE 6
`define FBRC_ASYNC 3
`define FBRC_LEN_HI 2
`define FBRC_LEN_LO 0
`define FBRC_SETUP_RST 16'h8000

// ----------------------------------------------------------------
// Length codes and block masks
// ----------------------------------------------------------------
`define FBRC_LEN1 3'b100
`define FBRC_LEN2 3'b101
`define FBRC_LEN4 3'b001
`define FBRC_LEN8 3'b010
`define FBRC_LENC 3'b111
`define FBRC_MASK1 3'h0
`define FBRC_MASK2 3'h1
`define FBRC_MASK4 3'h3
`define FBRC_MASK8 3'h7

// ----------------------------------------------------------------
// Latency codes and cycle values
// ----------------------------------------------------------------
`define FBRC_XC7 4'h2
`define FBRC_XC8 4'h3
`define FBRC_XC9 4'h4
`define FBRC_XC10 4'h5
`define FBRC_XC11 4'h6
`define FBRC_XC12 4'h9
`define FBRC_XC13 4'ha
`define FBRC_XC14 4'hb
`define FBRC_XC16 4'hd
`define FBRC_XV7 5'h07
`define FBRC_XV8 5'h08
`define FBRC_XV9 5'h09
`define FBRC_XV10 5'h0a
`define FBRC_XV11 5'h0b
`define FBRC_XV12 5'h0c
`define FBRC_XV13 5'h0d
`define FBRC_XV14 5'h0e
`define FBRC_XV16 5'h10
`define FBRC_XNONE 5'h00
`define FBRC_Y1 2'h1
`define FBRC_Y2 2'h2
`define FBRC_LAST 5'h01
`define FBRC_FETCH 5'h04
`define FBRC_ALIGN_HI 1

// ----------------------------------------------------------------
// Pin synchroniser layout
// ----------------------------------------------------------------
`define FBRC_AW 22
`define FBRC_PIN_W 27
`define FBRC_PIN_RST 27'h000000e
`define FBRC_P_K 0
`define FBRC_P_L 1
`define FBRC_P_B 2
`define FBRC_P_E 3
`define FBRC_P_W 4
`define FBRC_P_A 5

`endif

// [hw/fbrc_order.v]
// Address order generator for wrapped bursts
`timescale 1ns/100ps
`include "fbrc_defines.vh"

module fbrc_order (
  input wire [21:0] start,
  input wire [2:0] beat,
  input wire [2:0] mask,
  input wire seq,
  output reg [21:0] addr
);

  // Low bits inside the aligned block
  reg [2:0] low;

  // ----------------------------------------------------------------
  // Wrap within the block; high bits never change, so no crossing
  // ----------------------------------------------------------------
  always @* begin
    if (seq) begin
      low = (start[2:0] + beat) & mask; // R15
    end else begin
      low = (start[2:0] ^ beat) & mask; // R15
    end
    addr = {start[21:3], (start[2:0] & ~mask) | low}; // R14
  end

endmodule

// [verif/fbrc_burst_read_monitor.sv]
// Port checker for the burst read setup word and sequencer
`timescale 1ns/100ps

module fbrc_burst_read_monitor (
  input wire REF_CLK,
  input wire NRST,
  input wire SETUP_WR,
  input wire [15:0] SETUP_DATA,
  input wire WORD_X32,
  input wire [15:0] SETUP_WORD,
  input wire SETUP_REJECT,
  input wire SYNC_READ,
  input wire LATCH_CTRL_READ,
  input wire BEAT_STB,
  input wire BURST_BUSY,
  input wire READY_O,
  input wire READY_OE_N
);
  // ----------------------------------------
  // Common clock and reset
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // Burst-mode write, the only kind that can be refused
  wire burst_w = SETUP_WR & ~SETUP_DATA[15];
  wire [2:0] len = SETUP_DATA[2:0];

  // ----------------------------------------
  // Setup word checks
  // ----------------------------------------
  rst_state_a: assert property ($rose(NRST) |->
    SETUP_WORD == 16'h8000 && !SETUP_REJECT && READY_OE_N && !BEAT_STB)
    else $error("setup word not at reset value");
  async_take_a: assert property (SETUP_WR && SETUP_DATA[15] |=>
    SETUP_WORD == $past(SETUP_DATA) && !SETUP_REJECT) else $error("async word not taken");
  lat_resv_a: assert property (burst_w && SETUP_DATA[14:11] == 4'h1 |=>
    SETUP_REJECT && $stable(SETUP_WORD)) else $error("reserved latency taken");
  lat_seven_a: assert property (burst_w && SETUP_DATA[14:11] == 4'h2 && len != 3'b111 |=>
    SETUP_REJECT && $stable(SETUP_WORD)) else $error("latency seven taken");
  cont_order_a: assert property (burst_w && len == 3'b111 && !SETUP_DATA[7] |=>
    SETUP_REJECT) else $error("interleaved continuous taken");
  len_wide_a: assert property (burst_w && len == 3'b010 && WORD_X32 |=>
    SETUP_REJECT) else $error("length eight taken in x32");
  len_resv_a: assert property (burst_w && !(len inside {3'b100, 3'b101, 3'b001, 3'b010,
    3'b111}) |=> SETUP_REJECT) else $error("reserved length taken");
  mode_flags_a: assert property (SYNC_READ == !SETUP_WORD[15] &&
    LATCH_CTRL_READ == (SETUP_WORD[15] && SETUP_WORD[3])) else $error("mode flags wrong");

  // ----------------------------------------
  // Sequencer checks
  // ----------------------------------------
  beat_pulse_a: assert property (BEAT_STB |=> !BEAT_STB) else $error("beat longer than one");
  beat_busy_a: assert property (BEAT_STB |-> BURST_BUSY && SYNC_READ)
    else $error("beat outside a burst");
  wait_nobeat_a: assert property (!READY_OE_N |-> !BEAT_STB)
    else $error("beat while not ready");
  pin_low_a: assert property (READY_O == 1'b0) else $error("ready pin value not low");
endmodule

bind fbrc_burst_read fbrc_burst_read_monitor mon_u (.REF_CLK(REF_CLK), .NRST(NRST),
  .SETUP_WR(SETUP_WR), .SETUP_DATA(SETUP_DATA), .WORD_X32(WORD_X32),
  .SETUP_WORD(SETUP_WORD), .SETUP_REJECT(SETUP_REJECT), .SYNC_READ(SYNC_READ),
  .LATCH_CTRL_READ(LATCH_CTRL_READ), .BEAT_STB(BEAT_STB), .BURST_BUSY(BURST_BUSY),
  .READY_O(READY_O), .READY_OE_N(READY_OE_N));

// [verif/fbrc_ctrl_model.sv]
// Burst controller model that drives the burst pins
`timescale 1ns/100ps

module fbrc_ctrl_model (
  input wire clk,
  input wire rise,
  output reg kclk,
  output reg latch_n,
  output reg adv_n,
  output reg ce_n,
  output reg [21:0] addr
);
  integer edges; // Valid edges made so far
  integer cap; // Edge that captured the start address

  // ----------------------------------------
  // Idle pins; clock stands still
  // ----------------------------------------
  initial begin
    kclk = 1'b0;
    latch_n = 1'b1;
    adv_n = 1'b1;
    ce_n = 1'b1;
    addr = 22'h0;
    edges = 0;
    cap = 0;
  end

  // One burst of n valid edges after the capture edge
  task burst(input [21:0] a, input integer n, input integer p);
    begin
      @(posedge clk);
      ce_n <= 1'b0;
      adv_n <= 1'b0;
      latch_n <= 1'b0;
      addr <= a;
      cap = -1;
      while (cap < 0 || edges < cap + n) begin
        // Six cycles a level keeps the clock far below any latency limit
        repeat (6) @(posedge clk);
        kclk <= ~kclk;
        if (kclk != rise) begin
          edges = edges + 1;
          if (cap < 0)
            cap = edges;
        end else if (cap >= 0) begin
          // Strobe and bus move only between valid edges; a pulse around
          // edge cap+p queues the next burst, six or more edges early
          latch_n <= !(p > 0 && edges + 1 == cap + p);
          addr <= (p > 0 && edges + 1 == cap + p) ? a + 22'h000008 : ~a;
        end
      end
      repeat (6) @(posedge clk);
      ce_n <= 1'b1;
      adv_n <= 1'b1;
    end
  endtask
endmodule

// [verif/test_flash_burst_read_config.sv]
// Self-checking bench for the burst read setup word and sequencer
`timescale 1ns/100ps
`include "fbrc_defines.vh"

module test_flash_burst_read_config;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg setup_wr = 1'b0;
  reg [15:0] setup_data = 16'h0;
  reg word_x32 = 1'b0;
  reg [15:0] cur_w = 16'h8000; // Model of the stored word
  reg [31:0] seed = 32'h205f21c7;
  wire burst_clk, addr_latch_n, advance_n, chip_en_n;
  wire [21:0] addr, burst_addr;
  wire [15:0] setup_word;
  wire setup_reject, sync_read, latch_ctrl_read, beat_stb, burst_busy, ready_o, ready_oe_n;
  integer errors = 0;
  integer check_count = 0;
  integer nr_cyc = 0;
  integer k;
  reg [21:0] got_a[$];
  integer got_e[$];
  // Burst table: word, start, organisation, edges
  reg [15:0] cw [0:6] = '{16'h18c1, 16'h4a02, 16'h11c7, 16'h10c7, 16'h6885, 16'h3001, 16'h5244};
  reg [21:0] ca [0:6] = '{22'h5, 22'hd, 22'h10, 22'h13, 22'h3, 22'h2, 22'h7};
  reg cx [0:6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  integer cn [0:6] = '{40, 40, 24, 24, 40, 40, 40};
  integer cp [0:6] = '{4, 0, 0, 0, 6, 8, 0};

  always #4 ref_clk = ~ref_clk;

  fbrc_burst_read dut_u (.REF_CLK(ref_clk), .NRST(nrst), .SETUP_WR(setup_wr),
    .SETUP_DATA(setup_data), .BURST_CLK(burst_clk), .ADDR_LATCH_N(addr_latch_n),
    .ADVANCE_N(advance_n), .CHIP_EN_N(chip_en_n), .WORD_X32(word_x32), .ADDR(addr),
    .SETUP_WORD(setup_word), .SETUP_REJECT(setup_reject), .SYNC_READ(sync_read),
    .LATCH_CTRL_READ(latch_ctrl_read), .BURST_ADDR(burst_addr), .BEAT_STB(beat_stb),
    .BURST_BUSY(burst_busy), .READY_O(ready_o), .READY_OE_N(ready_oe_n));
  fbrc_ctrl_model ctl_u (.clk(ref_clk), .rise(cur_w[6]), .kclk(burst_clk),
    .latch_n(addr_latch_n), .adv_n(advance_n), .ce_n(chip_en_n), .addr(addr));

  // ----------------------------------------
  // Model helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // First-datum latency in burst edges, 0 for a reserved code
  function integer xlat(input [3:0] c);
    xlat = (c >= 4'h2 && c <= 4'h6) ? c + 5 : c == 4'h9 ? 12 : c == 4'ha ? 13 :
      c == 4'hb ? 14 : c == 4'hd ? 16 : 0;
  endfunction
  function ok_word(input [15:0] w, input x32);
    reg cont;
    reg lv;
    begin
      cont = w[2:0] == 3'b111;
      lv = w[2:0] == 3'b100 || w[2:0] == 3'b101 || w[2:0] == 3'b001 || cont ||
        (w[2:0] == 3'b010 && !x32);
      ok_word = w[15] || (lv && xlat(w[14:11]) != 0 && (xlat(w[14:11]) != 7 || cont) &&
        (w[7] || !cont));
    end
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task complete_run;
    begin
      if (errors == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Beat and not-ready recorder
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (beat_stb === 1'b1) begin
      got_a.push_back(burst_addr);
      got_e.push_back(ctl_u.edges);
    end
    if (ready_oe_n === 1'b0)
      nr_cyc = nr_cyc + 1;
  end

  // Setup write; refusal keeps the old word
  task wr(input [15:0] w);
    reg ok;
    begin
      ok = ok_word(w, word_x32);
      if (ok)
        cur_w = w;
      @(posedge ref_clk);
      setup_wr <= 1'b1;
      setup_data <= w;
      @(posedge ref_clk);
      setup_wr <= 1'b0;
      #1;
      chk(setup_word, cur_w);
      chk(setup_reject, !ok);
    end
  endtask

  // One burst compared beat by beat with the model
  task run(input [15:0] w, input [21:0] a, input x, input integer n, input integer p);
    integer xl, y, len, ex, nb, i, j, s, e0;
    begin
      word_x32 <= x;
      repeat (4) @(posedge ref_clk);
      wr(w);
      got_a.delete();
      got_e.delete();
      nr_cyc = 0;
      ctl_u.burst(a, n, p);
      repeat (8) @(posedge ref_clk);
      xl = xlat(w[14:11]);
      y = w[9] ? 2 : 1;
      len = w[2:0] == 3'b100 ? 1 : w[2:0] == 3'b101 ? 2 : w[2:0] == 3'b001 ? 4 :
        w[2:0] == 3'b010 ? 8 : 0;
      // Unaligned continuous start waits four edges for the fetch
      ex = (len == 0 && a[1:0] != 2'b00) ? 4 : 0;
      // Overlap only doubles the beats for blocks of four or eight
      nb = len == 0 ? (n - xl - ex) / y + 1 : (p > 0 && len >= 4) ? 2 * len : len;
      chk(got_a.size(), nb);
      for (i = 0; i < nb && i < got_a.size(); i++) begin
        j = len == 0 ? i : i % len;
        // Beats past the first block belong to the queued burst
        s = (len != 0 && i >= len) ? a + 8 : a;
        e0 = (len != 0 && i >= len) ? p : ex;
        chk(got_e[i], ctl_u.cap + e0 + xl + j * y);
        chk(got_a[i], len == 0 ? s + j :
          (s & ~(len - 1)) | ((w[7] ? s + j : s ^ j) & (len - 1)));
      end
      chk(nr_cyc != 0, ex != 0);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(setup_word, 16'h8000);
    chk({burst_busy, ready_oe_n, sync_read}, 3'b010);
    for (k = 0; k < 7; k++)
      run(cw[k], ca[k], cx[k], cn[k], cp[k]);
    // Random words, refused ones included
    for (k = 0; k < 60; k++) begin
      seed = xs(seed);
      word_x32 <= seed[16];
      repeat (4) @(posedge ref_clk);
      wr(seed[15:0]);
    end
    wr(16'h8000);
    repeat (6) @(posedge ref_clk);
    chk(burst_addr, addr);
    complete_run;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors = errors + 1;
    complete_run;
  end
endmodule
